// ===== logic/asr_pkg.sv
package asr_pkg;

    // =========================================================
    // Array geometry
    localparam int ASR_ADDR_W = 16;
    localparam int ASR_DATA_W = 16;
    localparam int ASR_BYTE_W = 8;

    // =========================================================
    // Timing at 125 MHz (8 ns period); slowest speed grade
    localparam int ASR_CLK_PS = 8000;
    localparam int ASR_T_AA_PS = 15000;
    localparam int ASR_T_WC_PS = 15000;
    localparam int ASR_T_HZ_PS = 7000;
    localparam int ASR_RD_CYC = (ASR_T_AA_PS + ASR_CLK_PS - 1) / ASR_CLK_PS + 1;
    localparam int ASR_WR_CYC = (ASR_T_WC_PS + ASR_CLK_PS - 1) / ASR_CLK_PS;
    localparam int ASR_HZ_CYC = (ASR_T_HZ_PS + ASR_CLK_PS - 1) / ASR_CLK_PS;
    localparam int ASR_CNT_W = 3;

    // =========================================================
    // Request from the user side
    typedef struct packed {
        logic write;
        logic [1:0] lanes;
        logic [ASR_ADDR_W-1:0] addr;
        logic [ASR_DATA_W-1:0] wdata;
    } asr_req_s;

    // Strobes toward the memory, all active low
    typedef struct packed {
        logic chip_sel_n;
        logic write_n;
        logic out_en_n;
        logic high_byte_lane_n;
        logic low_byte_lane_n;
    } asr_ctl_s;

    localparam asr_ctl_s ASR_CTL_IDLE = 5'h1F;

    typedef enum logic [3:0] {
        ASR_IDLE = 4'h1,
        ASR_READ = 4'h2,
        ASR_WRITE = 4'h4,
        ASR_TURN = 4'h8
    } asr_state_e;

endpackage : asr_pkg

// ===== logic/asr_host.sv
// Overview of operation
// - Any of those rising ends the write
// - Data held steady across the ending edge
// - Write strobe stays high through reads
// - Address set on the same edge that drops select
// - Read uses select and output enable low
`timescale 1ns/1ps
module asr_host
    import asr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // User request
    input wire logic req_valid,
    input wire asr_req_s req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [ASR_DATA_W-1:0] rsp_data,
    // Memory pins
    output logic [ASR_ADDR_W-1:0] mem_addr,
    output asr_ctl_s mem_ctl,
    output logic [ASR_DATA_W-1:0] mem_dq_o,
    output logic [1:0] mem_dq_oe_n,
    input wire logic [ASR_DATA_W-1:0] mem_dq_i
);

    // =========================================================
    // Decode
    asr_state_e state;
    asr_state_e next_state;
    logic [ASR_CNT_W-1:0] cnt;
    logic [ASR_CNT_W-1:0] next_cnt;
    logic [ASR_CNT_W-1:0] cnt_dec;
    logic cnt_done;
    logic start;
    logic in_access;
    logic access_end;
    logic read_end;
    logic [ASR_CNT_W-1:0] rd_load;
    logic [ASR_CNT_W-1:0] wr_load;
    logic [ASR_CNT_W-1:0] hz_load;
    logic [1:0] lanes_eff;
    logic [1:0] lanes_on;
    logic [ASR_DATA_W-1:0] lane_mask;

    // An access with no lane would do nothing; it is widened to the whole word
    function automatic logic [1:0] lane_fill(input logic [1:0] lanes);
        lane_fill = (lanes == 2'h0) ? 2'h3 : lanes;
    endfunction : lane_fill

    // Active-low lane strobes back to one enable bit per lane
    function automatic logic [1:0] lane_active(input asr_ctl_s ctl);
        lane_active = {!ctl.high_byte_lane_n, !ctl.low_byte_lane_n};
    endfunction : lane_active

    assign cnt_done = (cnt == '0);
    assign cnt_dec = cnt - ASR_CNT_W'(1);
    // Counts run from the load down to zero, so a phase lasts load plus one cycles
    assign rd_load = ASR_CNT_W'(ASR_RD_CYC - 1);
    assign wr_load = ASR_CNT_W'(ASR_WR_CYC - 1);
    assign hz_load = ASR_CNT_W'(ASR_HZ_CYC);

    // A request is taken only while the user side has been told it may be
    assign start = (state == ASR_IDLE) && req_valid && req_ready;
    assign in_access = (state == ASR_READ) || (state == ASR_WRITE);
    assign access_end = in_access && cnt_done;
    assign read_end = (state == ASR_READ) && cnt_done;
    assign lanes_eff = lane_fill(req.lanes);
    // Mask follows the strobes on the pins, so it always matches the access in flight
    assign lanes_on = lane_active(mem_ctl);

    // Lanes not read are zeroed since the memory floats them
    for (genvar g = 0; g < 2; g++) begin : g_lane
        assign lane_mask[g*ASR_BYTE_W +: ASR_BYTE_W] = {ASR_BYTE_W{lanes_on[g]}};
    end

    // =========================================================
    // Next state
    // Both kinds of access end on select and strobe rising together
    always_comb begin
        next_state = state;
        next_cnt = cnt_done ? cnt : cnt_dec;
        unique case (state)
            ASR_IDLE: begin
                if (start) begin
                    next_state = req.write ? ASR_WRITE : ASR_READ;
                    next_cnt = req.write ? wr_load : rd_load;
                end
            end
            ASR_READ: begin
                if (cnt_done) begin
                    next_state = ASR_TURN;
                    next_cnt = hz_load;
                end
            end
            ASR_WRITE: begin
                if (cnt_done) begin
                    next_state = ASR_TURN;
                    next_cnt = hz_load;
                end
            end
            // The turnaround lets the memory float its pins before the next access
            ASR_TURN: begin
                if (cnt_done) begin
                    next_state = ASR_IDLE;
                end
            end
        endcase
    end

    // =========================================================
    // Sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ASR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Phase counter; it only counts down to zero and waits there
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // =========================================================
    // Pin drive
    // Address and data are registered on the same edge that drops select,
    // and held until the next access starts; the data drivers are released on the edge after select and strobe have risen.
    // Holding one cycle past the ending edge gives the memory its data hold
    // without a separate timer; it costs one idle cycle per access.
    asr_ctl_s start_ctl;
    logic [1:0] start_oe_n;

    // Strobe levels for a new access
    assign start_ctl.chip_sel_n = 1'b0;
    assign start_ctl.write_n = !req.write;
    assign start_ctl.out_en_n = req.write;
    assign start_ctl.high_byte_lane_n = !lanes_eff[1];
    assign start_ctl.low_byte_lane_n = !lanes_eff[0];
    // Reads never drive the data pins, so the memory alone owns them
    assign start_oe_n = req.write ? ~lanes_eff : 2'h3;

    // Address and write data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr <= '0;
            mem_dq_o <= '0;
        end else if (start) begin
            mem_addr <= req.addr;
            mem_dq_o <= req.wdata;
        end
    end

    // Strobes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ctl <= ASR_CTL_IDLE;
        end else if (start) begin
            mem_ctl <= start_ctl;
        end else if (access_end) begin
            // Select and strobe rise together, so the memory keeps its outputs floating
            mem_ctl <= ASR_CTL_IDLE;
        end
    end

    // Data drivers are released one cycle after the strobes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_dq_oe_n <= 2'h3;
        end else if (start) begin
            mem_dq_oe_n <= start_oe_n;
        end else if (state == ASR_TURN) begin
            mem_dq_oe_n <= 2'h3;
        end
    end

    // =========================================================
    // User side
    logic next_req_ready;

    // Ready comes from the next state so it never lags a finished access
    assign next_req_ready = (next_state == ASR_IDLE);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
        end else begin
            req_ready <= next_req_ready;
            rsp_valid <= read_end;
        end
    end

    // Read data is captured on the edge that raises select and is held
    // until the next read ends
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_data <= '0;
        end else if (read_end) begin
            rsp_data <= mem_dq_i & lane_mask;
        end
    end

endmodule : asr_host

// ===== verif/asr_sram_model.sv
`timescale 1ns/1ps
// ========================================
// Behavioural 64K x 16 memory on the pins
module asr_sram_model
    import asr_pkg::*;
(
    // Pins from the host
    input wire logic [ASR_ADDR_W-1:0] mem_addr,
    input wire asr_ctl_s mem_ctl,
    input wire logic [ASR_DATA_W-1:0] mem_dq_o,
    input wire logic [1:0] mem_dq_oe_n,
    // Data back to the host
    output logic [ASR_DATA_W-1:0] mem_dq_i
);
    logic [ASR_DATA_W-1:0] mem [2**ASR_ADDR_W];
    wire wr = !mem_ctl.chip_sel_n && !mem_ctl.write_n;
    wire rd = !mem_ctl.chip_sel_n && !mem_ctl.out_en_n && mem_ctl.write_n;
    // A lane the host does not drive stores garbage
    wire [15:0] bus = mem_dq_o ^ {{8{mem_dq_oe_n[1]}}, {8{mem_dq_oe_n[0]}}};
    wire [15:0] cur = mem[mem_addr];
    always @(mem_ctl or mem_addr or bus) begin
        if (wr && !mem_ctl.low_byte_lane_n) mem[mem_addr][7:0] = bus[7:0];
        if (wr && !mem_ctl.high_byte_lane_n) mem[mem_addr][15:8] = bus[15:8];
    end
    // Floating lanes show inverted data so stale values cannot pass
    assign mem_dq_i[7:0] = (rd && !mem_ctl.low_byte_lane_n) ? cur[7:0] : ~cur[7:0];
    assign mem_dq_i[15:8] = (rd && !mem_ctl.high_byte_lane_n) ? cur[15:8] : ~cur[15:8];
endmodule : asr_sram_model

// ===== verif/asr_host_chk.sv
`timescale 1ns/1ps
// ========================================
// Pin protocol checks
module asr_host_chk
    import asr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Observed ports
    input wire logic req_valid,
    input wire asr_req_s req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [ASR_ADDR_W-1:0] mem_addr,
    input wire asr_ctl_s mem_ctl,
    input wire logic [ASR_DATA_W-1:0] mem_dq_o,
    input wire logic [1:0] mem_dq_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire cs = !mem_ctl.chip_sel_n;
    wire take = req_valid && req_ready;
    sequence rd_win; cs && !mem_ctl.out_en_n && mem_ctl.write_n; endsequence
    sequence wr_win; cs && !mem_ctl.write_n; endsequence
    rd_seq_a: assert property (take && !req.write |=> rd_win [*3] ##1 rsp_valid) else $error("bad read");
    wr_seq_a: assert property (take && req.write |=> wr_win [*2] ##1 (!cs && mem_ctl.write_n))
        else $error("bad write window");
    wr_hold_a: assert property ($rose(mem_ctl.write_n) |-> $stable(mem_dq_o) && mem_dq_oe_n != 2'h3)
        else $error("write data not held");
    rd_idle_a: assert property (cs && !mem_ctl.out_en_n |-> mem_ctl.write_n && mem_dq_oe_n == 2'h3)
        else $error("strobe or data during read");
    addr_hold_a: assert property (cs && $past(cs) |-> $stable(mem_addr)) else $error("address moved");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("response pulse too long");
    lane_sel_a: assert property (take |=> mem_addr == $past(req.addr) &&
        {mem_ctl.high_byte_lane_n, mem_ctl.low_byte_lane_n} == ($past(req.lanes) == 2'h0 ? 2'h0 : ~$past(req.lanes)))
        else $error("lanes or address wrong");
endmodule : asr_host_chk
bind asr_host asr_host_chk chk_i (.*);

// ===== verif/tb_top.sv
`timescale 1ns/1ps
// ========================================
// Host controller bench
module tb_top;
    import asr_pkg::*;
    logic ref_clk = 0, rst_n = 0, req_valid = 0, req_ready, rsp_valid;
    asr_req_s req = '0;
    logic [15:0] rsp_data, q, a, dq_o, dq_i;
    asr_ctl_s ctl;
    logic [1:0] oe_n;
    int num_errors = 0, checks_done = 0, cyc = 0;
    always #4 ref_clk = ~ref_clk;
    asr_host DUT (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_addr(a), .mem_ctl(ctl), .mem_dq_o(dq_o),
        .mem_dq_oe_n(oe_n), .mem_dq_i(dq_i));
    asr_sram_model mem_i (.mem_addr(a), .mem_ctl(ctl), .mem_dq_o(dq_o), .mem_dq_oe_n(oe_n), .mem_dq_i(dq_i));
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [1:0] l, input logic [15:0] ad, input logic [15:0] d);
        @(negedge ref_clk);
        for (int n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge ref_clk);
        // A host that never frees up counts as a mismatch, not a silent stall
        if (req_ready !== 1'b1) begin
            num_errors++;
            $display("mismatch t=%0t req_ready=%h exp=%h", $time, req_ready, 1'b1);
        end
        req_valid = 1;
        req = {w, l, ad, d};
        @(negedge ref_clk);
        req_valid = 0;
        for (int n = 0; n < 8 && !w && rsp_valid !== 1'b1; n++) @(negedge ref_clk);
        if (!w && rsp_valid !== 1'b1) begin
            num_errors++;
            $display("mismatch t=%0t rsp_valid=%h exp=%h", $time, rsp_valid, 1'b1);
        end
        q = rsp_data;
    endtask : acc
    task automatic t_lanes;
        acc(1, 2'h3, 16'hFFFF, 16'h1234);
        acc(1, 2'h1, 16'hFFFF, 16'hAB56);
        acc(1, 2'h2, 16'hFFFF, 16'h78CD);
        acc(0, 2'h3, 16'hFFFF, 16'h0000);
        chk(q, 16'h7856);
        acc(0, 2'h1, 16'hFFFF, 16'h0000);
        chk(q, 16'h0056);
        $display("t_lanes done");
    endtask : t_lanes
    task automatic t_whole;
        acc(1, 2'h0, 16'h0000, 16'hA5C3);
        acc(0, 2'h0, 16'h0000, 16'h0000);
        chk(q, 16'hA5C3);
        acc(0, 2'h2, 16'hFFFF, 16'h0000);
        chk(q, 16'h7800);
        $display("t_whole done");
    endtask : t_whole
    always @(posedge ref_clk) begin
        if (++cyc == 500) begin
            num_errors++;
            $display("mismatch t=%0t cycles=%h limit=%h", $time, cyc, 500);
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1;
        t_lanes();
        t_whole();
        report_and_stop();
    end
endmodule : tb_top
